// ==== rtl/idbank_params.svh ====
// Constants for the identity and inventory command bank.
// Assumes it is included by bare name from the bank's design file.
`ifndef IDBANK_PARAMS_SVH
`define IDBANK_PARAMS_SVH

// Command codes decoded by the bank.
`define CMD_MODEL_INFO 8'h9a
`define CMD_SUPPLIER_REV 8'h9b
`define CMD_SERIAL_NUM 8'h9e
`define CMD_PART_ID 8'had
`define CMD_SILICON_REV 8'hae

// Block lengths in bytes for each kind of command.
`define STORE_BYTES 4'h3
`define PART_ID_BYTES 4'h6
`define SILICON_REV_BYTES 4'h2
`define NO_BYTES 4'h0

// Index of each user store in the storage array.
`define IDX_MODEL_INFO 2'h0
`define IDX_SUPPLIER_REV 2'h1
`define IDX_SERIAL_NUM 2'h2

// Communication status layout and reset values.
`define STATUS_INVALID_CMD_MASK 8'h80
`define STATUS_CML_RESET 8'h00
`define STORE_RESET 24'h00_0000

`endif

// ==== rtl/idbank_pkg.sv ====
// Types shared by the identity and inventory command bank.
// Assumes nothing beyond a SystemVerilog compiler.
package idbank_pkg;
   // One three-byte user store word.
   typedef logic [23:0] store_word_t;
   // The widest block that a read can return.
   typedef logic [47:0] block_word_t;
   // A block length in bytes.
   typedef logic [3:0] byte_count_t;
endpackage

// ==== rtl/pmbus_identity_command_bank.sv ====
// Identity and inventory command bank behind the power-management bus.
// Assumes a protocol engine on the same clock that hands over whole block
// transfers as one-cycle strobes and forwards the read answer to the host.
//
// Functional notes
// - Writable 24-bit model information store.
// - 9Bh block write and 3-byte read.
// - 9Eh serial number block write, read, kept.
// - Serial number feeds the stored image checksum.
// - ADh returns fixed six bytes, byte0 lowest.
// - AEh returns fixed two bytes, never written.
// - Read-only write sets summary and bit 7.
// - Invalid command pulls the bus alert line low.
`timescale 1ns/10ps
`include "idbank_params.svh"

module pmbus_identity_command_bank
   import idbank_pkg::*;
#(
   // Part identification; the default value is arbitrary.
   parameter logic [47:0] PART_ID_VALUE = 48'h0123_4567_89ab,
   // Silicon revision fields; the default values are arbitrary.
   parameter logic [3:0] MAJOR_REV = 4'h1,
   parameter logic [3:0] MINOR_REV = 4'h0,
   parameter logic [7:0] SUB_MINOR_REV = 8'h00,
   // Width of the running byte sum of the stored image.
   parameter int CKSUM_W = 16
) (
   // Clock and reset.
   input wire logic REF_CLK_I,
   input wire logic RESET_N_I,
   // Command handed over by the protocol engine.
   input wire logic [7:0] CMD_I,
   input wire logic WR_STB_I,
   input wire byte_count_t WR_COUNT_I,
   input wire block_word_t WR_DATA_I,
   input wire logic RD_STB_I,
   // Read answer.
   output logic RD_VALID_O,
   output byte_count_t RD_COUNT_O,
   output block_word_t RD_DATA_O,
   // Fault clearing and nonvolatile restore.
   input wire logic FAULT_CLR_I,
   input wire logic NVM_LOAD_I,
   input wire logic [71:0] NVM_IMAGE_I,
   // Status and alert.
   output logic CML_SUMMARY_O,
   output logic [7:0] STATUS_CML_O,
   output logic ALERT_O,
   output logic ALERT_OE_N_O,
   // Byte sum over the user stores.
   output logic [CKSUM_W-1:0] CHECKSUM_O
);

   // Nine bytes of at most 255 each need twelve bits to sum without loss.
   generate
      if (CKSUM_W < 12) begin : g_bad_cksum_w
         $error("CKSUM_W must be at least 12");
      end
   endgenerate

   // Command decode, one wire per code.
   wire hit_model = (CMD_I == `CMD_MODEL_INFO);
   wire hit_rev = (CMD_I == `CMD_SUPPLIER_REV);
   wire hit_serial = (CMD_I == `CMD_SERIAL_NUM);
   wire hit_id = (CMD_I == `CMD_PART_ID);
   wire hit_sirev = (CMD_I == `CMD_SILICON_REV);
   // Writable user stores versus fixed read-only words.
   wire is_store = hit_model | hit_rev | hit_serial;
   wire is_ro = hit_id | hit_sirev;
   wire is_hit = is_store | is_ro;

   // Which user store the current command addresses.
   wire [1:0] store_idx = hit_model ? `IDX_MODEL_INFO :
                          hit_rev ? `IDX_SUPPLIER_REV : `IDX_SERIAL_NUM;

   // A store takes only a full three-byte block; a shorter or longer block
   // is dropped whole so that a store never holds a half-written value.
   wire store_we = WR_STB_I & is_store & (WR_COUNT_I == `STORE_BYTES);

   // Any write to a fixed word is an invalid command, whatever its length.
   wire invalid_command_fault = WR_STB_I & is_ro;

   // The user stores, held as flip-flops and addressed by index.
   store_word_t user_store_ff [0:2];

   // Silicon revision word built from its three fields.
   wire [15:0] si_rev_word = {MAJOR_REV, MINOR_REV, SUB_MINOR_REV};

   // Byte image over which the checksum runs, serial number included.
   wire [71:0] image_w = {user_store_ff[2], user_store_ff[1],
                          user_store_ff[0]};

   // Read data selection, narrower words padded with zero bytes above.
   wire [47:0] nxt_rd_data = is_store ? {24'h00_0000,
                                         user_store_ff[store_idx]} :
                             hit_id ? PART_ID_VALUE :
                             hit_sirev ? {32'h0000_0000, si_rev_word} :
                             48'h0000_0000_0000;
   // Read length selection.
   wire [3:0] nxt_rd_count = is_store ? `STORE_BYTES :
                             hit_id ? `PART_ID_BYTES :
                             hit_sirev ? `SILICON_REV_BYTES : `NO_BYTES;

   // Fault state next values; a new event beats a clear in the same cycle.
   wire nxt_cml = invalid_command_fault ? 1'b1 :
                  (FAULT_CLR_I ? 1'b0 : CML_SUMMARY_O);
   wire [7:0] nxt_status_cml = invalid_command_fault ?
                               (STATUS_CML_O | `STATUS_INVALID_CMD_MASK) :
                               (FAULT_CLR_I ? `STATUS_CML_RESET :
                                STATUS_CML_O);

   // Running byte sums, one stage per image byte.
   logic [CKSUM_W-1:0] part_sum [0:9];
   assign part_sum[0] = '0;

   genvar gi;
   generate
      // One flip-flop bank per user store.
      for (gi = 0; gi < 3; gi++) begin : g_store
         // A restore from the nonvolatile image wins over a host write,
         // since the restore engine owns the stores while it runs.
         always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
            if (!RESET_N_I) begin
               user_store_ff[gi] <= `STORE_RESET;
            end else if (NVM_LOAD_I) begin
               user_store_ff[gi] <= NVM_IMAGE_I[gi*24 +: 24];
            end else if (store_we && (store_idx == 2'(gi))) begin
               // Host content is taken as is, with no check.
               user_store_ff[gi] <= WR_DATA_I[23:0];
            end
         end
      end
      // One adder per image byte.
      for (gi = 0; gi < 9; gi++) begin : g_sum
         assign part_sum[gi+1] = part_sum[gi] +
                                 CKSUM_W'(image_w[gi*8 +: 8]);
      end
   endgenerate

   // Read answer: one cycle after the strobe, only for codes of this bank.
   always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         RD_VALID_O <= 1'b0;
         RD_COUNT_O <= `NO_BYTES;
         RD_DATA_O <= 48'h0000_0000_0000;
      end else begin
         RD_VALID_O <= RD_STB_I & is_hit;
         // Data and length stay put between reads to keep toggling down.
         if (RD_STB_I && is_hit) begin
            RD_COUNT_O <= nxt_rd_count;
            RD_DATA_O <= nxt_rd_data;
         end
      end
   end

   // Sticky fault flags; they hold until the engine relays a clear.
   always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         CML_SUMMARY_O <= 1'b0;
         STATUS_CML_O <= `STATUS_CML_RESET;
      end else begin
         CML_SUMMARY_O <= nxt_cml;
         STATUS_CML_O <= nxt_status_cml;
      end
   end

   // Open-drain alert: the pin only ever pulls low, and it does so in the
   // same cycle as the summary flag, so host and flag never disagree.
   always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         ALERT_O <= 1'b0;
         ALERT_OE_N_O <= 1'b1;
      end else begin
         ALERT_O <= 1'b0;
         ALERT_OE_N_O <= ~nxt_cml;
      end
   end

   // Checksum register; it follows any store change one cycle later.
   always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         CHECKSUM_O <= '0;
      end else begin
         CHECKSUM_O <= part_sum[9];
      end
   end

   // Reference sum for the checksum check. It is built store by store so
   // that the check does not lean on the adder chain that it judges.
   logic [CKSUM_W-1:0] ref_sum_w [0:2];
   generate
      // One three-byte sum per user store.
      for (gi = 0; gi < 3; gi++) begin : g_ref_sum
         assign ref_sum_w[gi] = CKSUM_W'(user_store_ff[gi][7:0]) +
                                CKSUM_W'(user_store_ff[gi][15:8]) +
                                CKSUM_W'(user_store_ff[gi][23:16]);
      end
   endgenerate
   // Whole-image reference total over the three stores.
   wire [CKSUM_W-1:0] ref_total_w = ref_sum_w[0] + ref_sum_w[1] +
                                    ref_sum_w[2];

   // A full model write lands in its store at the next edge.
   a_model_write: assert property (@(posedge REF_CLK_I)
      disable iff (!RESET_N_I)
      (WR_STB_I && hit_model && WR_COUNT_I == `STORE_BYTES && !NVM_LOAD_I)
      |=> user_store_ff[0] == $past(WR_DATA_I[23:0]))
      else $error("model store missed a write");

   // Supplier revision reads back three bytes of its store; a write in the
   // same cycle is not seen yet, so the store is taken at the read edge.
   a_rev_readback: assert property (@(posedge REF_CLK_I)
      disable iff (!RESET_N_I)
      (RD_STB_I && hit_rev) |=> (RD_VALID_O && RD_COUNT_O == `STORE_BYTES
      && RD_DATA_O == {24'h00_0000, $past(user_store_ff[1])}))
      else $error("supplier revision read wrong");

   // A store write of any other length is dropped whole.
   a_short_write_drop: assert property (@(posedge REF_CLK_I)
      disable iff (!RESET_N_I)
      (WR_STB_I && is_store && WR_COUNT_I != `STORE_BYTES && !NVM_LOAD_I)
      |=> ($stable(user_store_ff[0]) && $stable(user_store_ff[1])
      && $stable(user_store_ff[2])))
      else $error("short store write changed a store");

   // Serial number written, left alone a cycle, then read, comes back.
   sequence seq_serial_write;
      WR_STB_I && hit_serial && WR_COUNT_I == `STORE_BYTES && !NVM_LOAD_I;
   endsequence
   sequence seq_serial_gap;
      !WR_STB_I && !NVM_LOAD_I;
   endsequence
   sequence seq_serial_read;
      RD_STB_I && hit_serial && !WR_STB_I && !NVM_LOAD_I;
   endsequence
   a_serial_roundtrip: assert property (@(posedge REF_CLK_I)
      disable iff (!RESET_N_I)
      seq_serial_write ##1 seq_serial_gap ##1 seq_serial_read
      |=> RD_DATA_O[23:0] == $past(WR_DATA_I[23:0], 3))
      else $error("serial number did not read back");

   // The checksum follows the image, serial number bytes included.
   a_image_checksum: assert property (@(posedge REF_CLK_I)
      disable iff (!RESET_N_I)
      $changed(user_store_ff[2]) |=> CHECKSUM_O == $past(ref_total_w))
      else $error("checksum ignored a serial change");

   // Part identification returns its six fixed bytes.
   a_part_id_read: assert property (@(posedge REF_CLK_I)
      disable iff (!RESET_N_I)
      (RD_STB_I && hit_id) |=> (RD_VALID_O && RD_COUNT_O == `PART_ID_BYTES
      && RD_DATA_O == PART_ID_VALUE))
      else $error("part identification read wrong");

   // Silicon revision returns two bytes with its packed fields.
   a_sirev_fields: assert property (@(posedge REF_CLK_I)
      disable iff (!RESET_N_I)
      (RD_STB_I && hit_sirev) |=> (RD_COUNT_O == `SILICON_REV_BYTES
      && RD_DATA_O[15:12] == MAJOR_REV && RD_DATA_O[11:8] == MINOR_REV
      && RD_DATA_O[7:0] == SUB_MINOR_REV && RD_DATA_O[47:16] == '0))
      else $error("silicon revision read wrong");

   // A read of a code outside the bank gets no answer.
   a_foreign_read: assert property (@(posedge REF_CLK_I)
      disable iff (!RESET_N_I)
      (RD_STB_I && !is_hit) |=> !RD_VALID_O)
      else $error("foreign code was answered");

   // Length and data stand until the next read of this bank.
   a_read_holds: assert property (@(posedge REF_CLK_I)
      disable iff (!RESET_N_I)
      !(RD_STB_I && is_hit) |=> ($stable(RD_DATA_O)
      && $stable(RD_COUNT_O)))
      else $error("read answer moved without a read");

   // A write to a fixed word changes no store.
   a_ro_no_store: assert property (@(posedge REF_CLK_I)
      disable iff (!RESET_N_I)
      (WR_STB_I && is_ro && !NVM_LOAD_I) |=> ($stable(user_store_ff[0])
      && $stable(user_store_ff[1]) && $stable(user_store_ff[2])))
      else $error("read-only write changed a store");

   // A read-only write sets both flags, even against a clear.
   a_invalid_cmd_flags: assert property (@(posedge REF_CLK_I)
      disable iff (!RESET_N_I)
      (WR_STB_I && is_ro) |=> (CML_SUMMARY_O && STATUS_CML_O[7]
      && STATUS_CML_O[6:0] == 7'h00))
      else $error("invalid command not flagged");

   // A clear that meets a new invalid command is lost; the alert stays.
   a_clear_race: assert property (@(posedge REF_CLK_I)
      disable iff (!RESET_N_I)
      (invalid_command_fault && FAULT_CLR_I) |=> (CML_SUMMARY_O
      && !ALERT_OE_N_O))
      else $error("clear beat a new invalid command");

   // Alert pulls low exactly while the summary flag is set.
   a_alert_tracks: assert property (@(posedge REF_CLK_I)
      disable iff (!RESET_N_I)
      (ALERT_OE_N_O == !CML_SUMMARY_O) && !ALERT_O)
      else $error("alert pin disagrees with summary");

   // A clear without a new event releases the alert at the next edge.
   a_alert_release: assert property (@(posedge REF_CLK_I)
      disable iff (!RESET_N_I)
      (FAULT_CLR_I && !invalid_command_fault) |=> (ALERT_OE_N_O
      && !CML_SUMMARY_O && STATUS_CML_O == `STATUS_CML_RESET))
      else $error("clear did not release alert");

   // A restore loads all three stores, ahead of any host write.
   a_restore_load: assert property (@(posedge REF_CLK_I)
      disable iff (!RESET_N_I)
      NVM_LOAD_I |=> ({user_store_ff[2], user_store_ff[1],
      user_store_ff[0]} == $past(NVM_IMAGE_I)))
      else $error("restore did not load the stores");

endmodule

// ==== testbench/host_model.sv ====
// Host controller model that issues whole block transfers to the bank.
// Assumes the bank takes a strobe on a rising edge and answers a read
// one cycle later.
`timescale 1ns/10ps

module host_model
   import idbank_pkg::*;
(
   // Clock.
   input wire logic clk_i,
   // Request towards the bank.
   output logic [7:0] cmd_o,
   output logic wr_stb_o,
   output byte_count_t wr_count_o,
   output block_word_t wr_data_o,
   output logic rd_stb_o,
   // Answer from the bank.
   input wire logic rd_valid_i,
   input wire byte_count_t rd_count_i,
   input wire block_word_t rd_data_i
);
   // Idle values at time zero, so that no bank input floats.
   initial begin
      cmd_o = 8'h00;
      wr_stb_o = 1'b0;
      wr_count_o = 4'h0;
      wr_data_o = 48'h0000_0000_0000;
      rd_stb_o = 1'b0;
   end

   // Block write; only a scenario about refusals aims it at a read-only
   // word. Released lines show the inverse, so stale data never matches.
   task automatic block_write(input logic [7:0] cmd, input byte_count_t cnt,
                              input block_word_t data);
      @(posedge clk_i);
      cmd_o <= cmd;
      wr_count_o <= cnt;
      wr_data_o <= data;
      wr_stb_o <= 1'b1;
      @(posedge clk_i);
      wr_stb_o <= 1'b0;
      wr_data_o <= ~data;
      cmd_o <= ~cmd;
   endtask

   // Block read; the answer is taken once the taking edge has settled.
   task automatic block_read(input logic [7:0] cmd, output logic vld,
                             output byte_count_t cnt, output block_word_t d);
      @(posedge clk_i);
      cmd_o <= cmd;
      rd_stb_o <= 1'b1;
      @(posedge clk_i);
      rd_stb_o <= 1'b0;
      cmd_o <= ~cmd;
      #1;
      vld = rd_valid_i;
      cnt = rd_count_i;
      d = rd_data_i;
   endtask
endmodule

// ==== testbench/tb_pmbus_identity_command_bank.sv ====
// Self-checking bench for the identity and inventory command bank.
// Assumes the bank's header and package are compiled first.
`timescale 1ns/10ps
`include "idbank_params.svh"

module tb_pmbus_identity_command_bank
   import idbank_pkg::*;
;
   // Arbitrary identity values handed to the bank.
   localparam block_word_t PART_ID = 48'h0a1b_2c3d_4e5f;
   localparam logic [15:0] REV = 16'h357c;
   logic ref_clk = 1'b0, reset_n = 1'b0, wr_stb, rd_stb, rd_valid;
   logic fault_clr = 1'b0, nvm_load = 1'b0, cml_summary, alert, alert_oe_n;
   logic [7:0] cmd, status_cml;
   byte_count_t wr_count, rd_count;
   block_word_t wr_data, rd_data;
   logic [71:0] nvm_image = 72'h00_0000_0000_0000_0000;
   logic [15:0] checksum;
   int failures = 0, check_count = 0;
   store_word_t st [3];
   logic [7:0] codes [3] = '{`CMD_MODEL_INFO, `CMD_SUPPLIER_REV,
                             `CMD_SERIAL_NUM};
   // The alert pin is open drain with a pull-up on the board.
   wire alert_pin = alert_oe_n ? 1'b1 : alert;

   // Clock at 200 MHz.
   always #2.5 ref_clk = ~ref_clk;

   host_model host (.clk_i(ref_clk), .cmd_o(cmd), .wr_stb_o(wr_stb),
      .wr_count_o(wr_count), .wr_data_o(wr_data), .rd_stb_o(rd_stb),
      .rd_valid_i(rd_valid), .rd_count_i(rd_count), .rd_data_i(rd_data));
   pmbus_identity_command_bank #(.PART_ID_VALUE(PART_ID),
      .MAJOR_REV(REV[15:12]), .MINOR_REV(REV[11:8]),
      .SUB_MINOR_REV(REV[7:0]), .CKSUM_W(16)) DUT (.REF_CLK_I(ref_clk),
      .RESET_N_I(reset_n), .CMD_I(cmd), .WR_STB_I(wr_stb),
      .WR_COUNT_I(wr_count), .WR_DATA_I(wr_data), .RD_STB_I(rd_stb),
      .RD_VALID_O(rd_valid), .RD_COUNT_O(rd_count), .RD_DATA_O(rd_data),
      .FAULT_CLR_I(fault_clr), .NVM_LOAD_I(nvm_load),
      .NVM_IMAGE_I(nvm_image), .CML_SUMMARY_O(cml_summary),
      .STATUS_CML_O(status_cml), .ALERT_O(alert),
      .ALERT_OE_N_O(alert_oe_n), .CHECKSUM_O(checksum));

   // Compare tasks, one for words and one for single bits.
   task automatic chk_word(input block_word_t got, exp, input string what);
      check_count++;
      if (got !== exp) begin
         $display("MISMATCH t=%0t %s", $time, what);
         failures++;
      end
   endtask
   task automatic chk_bit(input logic got, exp, input string what);
      chk_word({47'h0, got}, {47'h0, exp}, what);
   endtask

   // One block read, judged on valid, count and data together.
   task automatic rd_check(input logic [7:0] c, input byte_count_t n,
                           input block_word_t d);
      logic v;
      byte_count_t gn;
      block_word_t gd;
      host.block_read(c, v, gn, gd);
      chk_bit(v, 1'b1, "read valid");
      chk_word({44'h0, gn}, {44'h0, n}, "read count");
      chk_word(gd, d, "read data");
      // The valid pulse must be gone one cycle later.
      @(posedge ref_clk);
      #1 chk_bit(rd_valid, 1'b0, "valid one cycle");
   endtask

   // Expected byte sum of the nine store bytes.
   function automatic logic [15:0] image_sum();
      logic [15:0] s = 16'h0000;
      for (int i = 0; i < 9; i++) s += st[i / 3][8 * (i % 3) +: 8];
      return s;
   endfunction

   // Each store is written and read back; a short write must be ignored.
   task automatic t_stores();
      for (int i = 0; i < 3; i++) begin
         st[i] = 24'h5a_c3_e1 ^ {3{8'(i + 1)}};
         host.block_write(codes[i], `STORE_BYTES, {24'h0, st[i]});
         host.block_write(codes[i], 4'h2, {24'h0, ~st[i]});
         rd_check(codes[i], `STORE_BYTES, {24'h0, st[i]});
      end
      @(posedge ref_clk);
      #1 chk_word({32'h0, checksum}, {32'h0, image_sum()}, "sum");
      st[2] = 24'h00_0101;
      host.block_write(`CMD_SERIAL_NUM, `STORE_BYTES, {24'h0, st[2]});
      rd_check(`CMD_SERIAL_NUM, `STORE_BYTES, {24'h0, st[2]});
      repeat (2) @(posedge ref_clk);
      #1 chk_word({32'h0, checksum}, {32'h0, image_sum()}, "sum 2");
      $display("test stores done");
   endtask

   // Fixed words read back with their lengths and byte order.
   task automatic t_fixed();
      logic v;
      byte_count_t gn;
      block_word_t gd;
      rd_check(`CMD_PART_ID, `PART_ID_BYTES, PART_ID);
      rd_check(`CMD_SILICON_REV, `SILICON_REV_BYTES, {32'h0, REV});
      // A code outside the bank is not answered and the old answer stands.
      host.block_read(8'h98, v, gn, gd);
      chk_bit(v, 1'b0, "foreign read answered");
      chk_word({44'h0, gn}, {44'h0, `SILICON_REV_BYTES}, "count held");
      chk_word(gd, {32'h0, REV}, "answer held");
      $display("test fixed done");
   endtask

   // Writes to read-only words raise the fault, alert, then clear.
   task automatic t_ro_write();
      for (int k = 0; k < 2; k++) begin
         host.block_write(k ? `CMD_SILICON_REV : `CMD_PART_ID, 4'h2,
                          48'hffff_ffff_ffff);
         #1 chk_bit(cml_summary, 1'b1, "summary set");
         chk_word({40'h0, status_cml}, 48'h80, "status set");
         chk_bit(alert_pin, 1'b0, "alert low");
         rd_check(`CMD_SILICON_REV, `SILICON_REV_BYTES, {32'h0, REV});
         @(posedge ref_clk) fault_clr <= 1'b1;
         @(posedge ref_clk) fault_clr <= 1'b0;
         #1 chk_word({40'h0, status_cml}, 48'h0, "status clear");
         chk_bit(alert_pin, 1'b1, "alert released");
         chk_bit(cml_summary, 1'b0, "summary clear");
      end
      // A clear in the very cycle of a new invalid write is lost.
      fork
         host.block_write(`CMD_PART_ID, `PART_ID_BYTES, 48'h0);
         begin
            @(posedge ref_clk) fault_clr <= 1'b1;
            @(posedge ref_clk) fault_clr <= 1'b0;
         end
      join
      #1 chk_bit(cml_summary, 1'b1, "set beats clear");
      chk_bit(alert_pin, 1'b0, "alert kept");
      @(posedge ref_clk) fault_clr <= 1'b1;
      @(posedge ref_clk) fault_clr <= 1'b0;
      #1 chk_bit(cml_summary, 1'b0, "summary clear 2");
      chk_bit(alert_pin, 1'b1, "alert released 2");
      $display("test read-only write done");
   endtask

   // Stores restored from the nonvolatile image read back intact.
   task automatic t_restore();
      st = '{24'h11_2233, 24'h44_5566, 24'h77_8899};
      @(posedge ref_clk);
      nvm_image <= {st[2], st[1], st[0]};
      nvm_load <= 1'b1;
      @(posedge ref_clk) nvm_load <= 1'b0;
      for (int i = 0; i < 3; i++)
         rd_check(codes[i], `STORE_BYTES, {24'h0, st[i]});
      $display("test restore done");
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // Main sequence: reset for five cycles, then the scenarios.
   initial begin
      repeat (5) @(posedge ref_clk);
      reset_n <= 1'b1;
      #1 chk_bit(alert_pin, 1'b1, "alert idle");
      t_stores();
      t_fixed();
      t_ro_write();
      t_restore();
      tally_and_finish();
   end

   // Watchdog well beyond the fewer than a hundred cycles the tests need.
   initial begin
      #20000;
      failures++;
      tally_and_finish();
   end
endmodule
